// ### common/adc_pkg.sv
// Constants shared by the converter control block and its helpers.
// Assumes an 8-bit register port and a single 100 MHz system clock.
package adc_pkg;

  // Register indices on the plain register port.
  localparam logic [2:0] ADDR_RUN_CTRL   = 3'h0;
  localparam logic [2:0] ADDR_REF_PIN    = 3'h1;
  localparam logic [2:0] ADDR_CLK_FMT    = 3'h2;
  localparam logic [2:0] ADDR_RES_HIGH   = 3'h3;
  localparam logic [2:0] ADDR_RES_LOW    = 3'h4;
  localparam logic [2:0] ADDR_IRQ_STATUS = 3'h5;
  localparam logic [2:0] ADDR_IRQ_MASK   = 3'h6;

  // Field positions in the run control register.
  localparam int ENABLE_BIT  = 0;
  localparam int GO_BIT      = 1;
  localparam int CHAN_LSB    = 2;
  // Field positions in the reference and pin register.
  localparam int PIN_LSB     = 0;
  localparam int REF_LSB     = 4;
  // Field positions in the clock and format register.
  localparam int CLKSEL_LSB  = 0;
  localparam int JUSTIFY_BIT = 7;
  // Interrupt status and mask bits.
  localparam int IRQ_DONE_BIT    = 0;
  localparam int IRQ_REFUSED_BIT = 1;

  // Values after reset.
  localparam logic [5:0] RUN_CTRL_RESET = 6'h00;
  localparam logic [5:0] REF_PIN_RESET  = 6'h00;
  localparam logic [3:0] CLK_FMT_RESET  = 4'h0;
  localparam logic [7:0] RESULT_RESET   = 8'h00;
  localparam logic [1:0] IRQ_RESET      = 2'h0;

  // Conversion length in bit periods, and result width.
  localparam logic [3:0] TAD_PER_CONV = 4'hC;
  localparam int         RESULT_BITS  = 10;

  // System clock dividers per clock select code.
  localparam logic [6:0] DIV_2  = 7'h02;
  localparam logic [6:0] DIV_4  = 7'h04;
  localparam logic [6:0] DIV_8  = 7'h08;
  localparam logic [6:0] DIV_16 = 7'h10;
  localparam logic [6:0] DIV_32 = 7'h20;
  localparam logic [6:0] DIV_64 = 7'h40;

  // Conversion sequencer states.
  typedef enum logic [0:0] {
    ST_IDLE    = 1'b0,
    ST_CONVERT = 1'b1
  } conv_state_t;

endpackage

// ### dv/adc_control_props.sv
// Port checker for the converter control block.
// Assumes one clock and a clock enable held high.
`timescale 1ns/1ns
module adc_control_props #(
  parameter int NUM_CHANNELS = 16
) (
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic [2:0]  addr,
  input wire logic [7:0]  wdata,
  input wire logic        write,
  input wire logic        read,
  input wire logic [7:0]  rdata,
  input wire logic [3:0]  input_channel_select,
  input wire logic        channel_valid,
  input wire logic        converter_on,
  input wire logic        conv_start,
  input wire logic        conv_active,
  input wire logic        conv_bit_tick
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  wire       ctrl_wr = write && addr == 3'h0;  // Write to the run control register.
  logic [3:0] tick_cnt;                          // Bit periods seen in this conversion.
  // The count restarts whenever the sequencer is idle.
  always_ff @(posedge clk) begin
    tick_cnt <= (!resetn || !conv_active) ? 4'h0 : tick_cnt + {3'h0, conv_bit_tick};
  end
  ////////////////////////////////////////////////////////////////
  a_read_idle: assert property (!$past(read) |-> rdata == 8'h00) else $error("read data not idle");
  a_pad_zero: assert property (read && addr <= 3'h1 |=> rdata[7:6] == 2'b00) else $error("pad bits set");
  a_unmapped_zero: assert property (read && addr == 3'h7 |=> rdata == 8'h00) else $error("unmapped read");
  a_go_busy: assert property (read && addr == 3'h0 && conv_active |=> rdata[1:0] == 2'b11)
    else $error("go bit low while busy");
  a_start_accept: assert property (ctrl_wr && wdata[1:0] == 2'b11 && !conv_active |=> conv_start && conv_active)
    else $error("start not taken");
  a_no_start_off: assert property (ctrl_wr && !wdata[0] |=> !conv_start && !conv_active)
    else $error("runs while off");
  a_twelve_ticks: assert property ($fell(conv_active) && !$past(ctrl_wr) |-> $past(tick_cnt) == 4'hB && $past(conv_bit_tick))
    else $error("conversion length wrong");
  a_ticks_bounded: assert property (conv_bit_tick |-> conv_active && tick_cnt < 4'hC) else $error("extra tick");
  a_hold_busy: assert property (conv_active && !conv_bit_tick && !ctrl_wr |=> conv_active)
    else $error("conversion dropped");
  a_active_on: assert property (conv_active |-> converter_on) else $error("active while off");
  a_chan_valid: assert property (channel_valid == (input_channel_select < NUM_CHANNELS))
    else $error("channel validity wrong");
  c_complete: cover property ($fell(conv_active));
  c_refused: cover property (ctrl_wr && wdata[1:0] == 2'b10);
  c_unmapped: cover property (read && addr == 3'h7);
endmodule
bind adc_control_registers adc_control_props #(.NUM_CHANNELS(NUM_CHANNELS)) u_adc_control_props (
  .clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .write(write), .read(read), .rdata(rdata),
  .input_channel_select(input_channel_select), .channel_valid(channel_valid), .converter_on(converter_on),
  .conv_start(conv_start), .conv_active(conv_active), .conv_bit_tick(conv_bit_tick));

// ### dv/adc_core_model.sv
// Model of the input multiplexer, converter core and RC oscillator.
// Assumes the control block drives channel and validity from clk.
`timescale 1ns/1ns
module adc_core_model #(
  parameter int RC_PERIOD = 7  // Oscillator tick spacing in clk cycles.
) (
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       resetn,
  // From the control block.
  input  wire logic [3:0] input_channel_select,
  input  wire logic       channel_valid,
  // To the control block.
  output logic            rc_tick,
  output logic      [9:0] core_result
);
  int rc_count;  // Oscillator phase; it runs free, as a real oscillator does.
  always_ff @(posedge clk) begin
    rc_count <= (!resetn || rc_count == RC_PERIOD - 1) ? 0 : rc_count + 1;
    rc_tick  <= resetn && rc_count == RC_PERIOD - 1;
  end
  // An absent channel converts as zero, so a wrong route shows in the result.
  always_ff @(posedge clk) begin
    core_result <= channel_valid ? {input_channel_select, 6'h2D} : 10'h000;
  end
endmodule

// ### dv/tb_adc_control_registers.sv
// Self-checking bench for the converter control block.
// Assumes the core model and the bound port checker beside it.
`timescale 1ns/1ns
module tb_adc_control_registers;
  localparam int NCH    = 16;  // Large package.
  localparam int RC_PER = 7;   // Oscillator spacing in clk cycles.
  logic        clk    = 1'b0;
  logic        resetn = 1'b0;
  logic [2:0]  addr   = 3'h0;
  logic [7:0]  wdata  = 8'h00;
  logic        write  = 1'b0;
  logic        read   = 1'b0;
  logic [7:0]  rdata;
  logic        irq, rc_tick, channel_valid, converter_on, conv_start, conv_active, conv_bit_tick, small_valid;
  logic [9:0]  core_result, res;
  logic [3:0]  input_channel_select;
  logic [1:0]  reference_select;
  logic [15:0] analog_pin_mask, small_mask;
  int          fail_count  = 0;
  int          checks_done = 0;
  int          n;
  logic [2:0]  codes [8] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6, 3'h3, 3'h7};  // Clock select codes.
  int          divs  [8] = '{2, 8, 32, 4, 16, 64, RC_PER, RC_PER};          // Cycles per bit period.
  initial begin
    forever #5 clk = ~clk;
  end
  adc_control_registers #(.NUM_CHANNELS(NCH)) u_adc_control_registers (
    .clk(clk), .resetn(resetn), .ce(1'b1), .addr(addr), .wdata(wdata), .write(write), .read(read),
    .rdata(rdata), .irq(irq), .rc_tick(rc_tick), .core_result(core_result),
    .input_channel_select(input_channel_select), .channel_valid(channel_valid),
    .reference_select(reference_select), .analog_pin_mask(analog_pin_mask), .converter_on(converter_on),
    .conv_start(conv_start), .conv_active(conv_active), .conv_bit_tick(conv_bit_tick));
  adc_core_model #(.RC_PERIOD(RC_PER)) u_adc_core_model (
    .clk(clk), .resetn(resetn), .input_channel_select(input_channel_select),
    .channel_valid(channel_valid), .rc_tick(rc_tick), .core_result(core_result));
  // Small package copy on the same bus; only its channel and pin outputs are compared.
  adc_control_registers #(.NUM_CHANNELS(12)) u_adc_control_registers_small (
    .clk(clk), .resetn(resetn), .ce(1'b1), .addr(addr), .wdata(wdata), .write(write), .read(read),
    .rdata(), .irq(), .rc_tick(rc_tick), .core_result(core_result), .input_channel_select(),
    .channel_valid(small_valid), .reference_select(), .analog_pin_mask(small_mask), .converter_on(),
    .conv_start(), .conv_active(), .conv_bit_tick());
  ////////////////////////////////////////////////////////////////
  // Compares one value; unknowns never match.
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One-cycle write; returns at the edge that takes it.
  task automatic reg_write(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    write <= 1'b1;
    @(posedge clk);
    write <= 1'b0;
  endtask
  // One-cycle read; data is taken mid-cycle, the only cycle it stands.
  task automatic expect_reg(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    read <= 1'b1;
    @(posedge clk);
    read <= 1'b0;
    @(negedge clk);
    check({8'h00, rdata}, {8'h00, e});
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  // The slowest conversion is under 800 cycles; the whole run is far below this bound.
  initial begin
    #200000;
    fail_count++;
    summarize();
  end
  initial begin
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      expect_reg(3'(i), 8'h00);
    end
    check(analog_pin_mask, 16'hFFFF);
    check(small_mask, 16'h0FFF);
    reg_write(adc_pkg::ADDR_CLK_FMT, 8'hFF);
    expect_reg(adc_pkg::ADDR_CLK_FMT, 8'h87);
    reg_write(adc_pkg::ADDR_RES_HIGH, 8'hFF);
    expect_reg(adc_pkg::ADDR_RES_HIGH, 8'h00);
    $display("test registers done");
    for (int r = 0; r < 4; r++) begin
      reg_write(adc_pkg::ADDR_REF_PIN, 8'(r << 4) | 8'hC0);
      @(negedge clk);
      check({14'h0, reference_select}, 16'(r));
      expect_reg(adc_pkg::ADDR_REF_PIN, 8'(r << 4));
    end
    // The mask trails the pin code by one cycle, hence a wait to the second falling edge.
    for (int c = 0; c < 16; c++) begin
      reg_write(adc_pkg::ADDR_REF_PIN, 8'(c));
      repeat (2) @(negedge clk);
      check(analog_pin_mask, (c == 0) ? 16'hFFFF : 16'(32'h0000FFFF >> (c + 1)));
      check(small_mask, ((c == 0) ? 16'hFFFF : 16'(32'h0000FFFF >> (c + 1))) & 16'h0FFF);
    end
    for (int ch = 0; ch < 16; ch++) begin
      reg_write(adc_pkg::ADDR_RUN_CTRL, 8'(ch << 2) | 8'hC0);
      @(negedge clk);
      check({input_channel_select, 11'h0, channel_valid}, {4'(ch), 11'h0, ch < NCH});
      check({15'h0, small_valid}, {15'h0, ch < 12});
      expect_reg(adc_pkg::ADDR_RUN_CTRL, 8'(ch << 2));
    end
    $display("test fields done");
    // Every clock code, alternating justification, each on its own channel.
    reg_write(adc_pkg::ADDR_IRQ_MASK, 8'h01);
    for (int i = 0; i < 8; i++) begin
      reg_write(adc_pkg::ADDR_CLK_FMT, {i[0], 4'h0, codes[i]});
      reg_write(adc_pkg::ADDR_RUN_CTRL, 8'(i << 2) | 8'h03);
      n = 0;
      @(negedge clk);
      while (conv_active === 1'b1 && n < 2000) begin
        n++;
        @(negedge clk);
      end
      // The oscillator phase is free, so its count may fall one period short.
      if (i >= 6 && n >= 11 * RC_PER && n <= 12 * RC_PER) begin
        n = 12 * RC_PER;
      end
      check(16'(n), 16'(12 * divs[i]));
      check({15'h0, irq}, 16'h0001);
      res = {4'(i), 6'h2D};
      expect_reg(adc_pkg::ADDR_RES_HIGH, i[0] ? {6'h00, res[9:8]} : res[9:2]);
      expect_reg(adc_pkg::ADDR_RES_LOW, i[0] ? res[7:0] : {res[1:0], 6'h00});
      expect_reg(adc_pkg::ADDR_RUN_CTRL, 8'(i << 2) | 8'h01);
      expect_reg(adc_pkg::ADDR_IRQ_STATUS, 8'h01);
      reg_write(adc_pkg::ADDR_IRQ_STATUS, 8'h01);
      @(negedge clk);
      check({15'h0, irq}, 16'h0000);
    end
    $display("test conversions done");
    // A start while off is refused and flagged; the flag raises irq only once unmasked.
    reg_write(adc_pkg::ADDR_IRQ_MASK, 8'h00);
    reg_write(adc_pkg::ADDR_RUN_CTRL, 8'h02);
    @(negedge clk);
    check({14'h0, conv_active, irq}, 16'h0000);
    expect_reg(adc_pkg::ADDR_IRQ_STATUS, 8'h02);
    reg_write(adc_pkg::ADDR_IRQ_MASK, 8'h02);
    @(negedge clk);
    check({15'h0, irq}, 16'h0001);
    reg_write(adc_pkg::ADDR_IRQ_STATUS, 8'h02);
    @(negedge clk);
    check({15'h0, irq}, 16'h0000);
    $display("test refused start done");
    // A slow conversion is polled, given a second start in flight that is ignored, then switched off.
    reg_write(adc_pkg::ADDR_CLK_FMT, 8'h06);
    reg_write(adc_pkg::ADDR_RUN_CTRL, 8'h17);
    expect_reg(adc_pkg::ADDR_RUN_CTRL, 8'h17);
    reg_write(adc_pkg::ADDR_RUN_CTRL, 8'h17);
    @(negedge clk);
    check({15'h0, conv_active}, 16'h0001);
    reg_write(adc_pkg::ADDR_RUN_CTRL, 8'h14);
    @(negedge clk);
    check({14'h0, converter_on, conv_active}, 16'h0000);
    expect_reg(adc_pkg::ADDR_RUN_CTRL, 8'h14);
    expect_reg(adc_pkg::ADDR_IRQ_STATUS, 8'h00);
    // The last finished conversion was right justified.
    expect_reg(adc_pkg::ADDR_RES_HIGH, {6'h00, res[9:8]});
    $display("test abort done");
    summarize();
  end
endmodule

// ### src/adc_control_registers.sv
// Register file and conversion sequencer of a 10-bit successive
// approximation converter with up to sixteen multiplexed inputs.
// Assumes the converter core presents its 10-bit result on core_result
// by the last bit period tick, and that rc_tick is clk-synchronous.
// Assumes software changes the clock code only while idle.
//
// Added by the designer: the address-and-strobe port and the address map.
`timescale 1ns/1ns
module adc_control_registers #(
  parameter int NUM_CHANNELS = 16  // 16 on the large package, 12 on the small.
) (
  // Clock, reset, enable.
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        ce,
  // Register port.
  input  wire logic [2:0]  addr,
  input  wire logic [7:0]  wdata,
  input  wire logic        write,
  input  wire logic        read,
  output logic      [7:0]  rdata,
  // Interrupt.
  output logic             irq,
  // Converter core and multiplexer.
  input  wire logic        rc_tick,
  input  wire logic [9:0]  core_result,
  output logic      [3:0]  input_channel_select,
  output logic             channel_valid,
  output logic      [1:0]  reference_select,
  output logic      [15:0] analog_pin_mask,
  output logic             converter_on,
  output logic             conv_start,
  output logic             conv_active,
  output logic             conv_bit_tick
);

  ////////////////////////////////////////////////////////////////////////////
  // Register state.

  // Every field resets to zero, results too, so a first read is defined.
  logic        module_enable_bit;        // Converter powered.
  logic        go_done;                  // Conversion running.
  logic [3:0]  pin_function_select;      // Analog or digital pin code.
  logic        result_justify_select;    // One is right justified.
  logic [2:0]  conversion_clock_select;  // Bit period source.
  logic [7:0]  result_high_byte;         // Upper result byte.
  logic [7:0]  result_low_byte;          // Lower result byte.
  logic [1:0]  irq_status;               // Sticky event bits.
  logic [1:0]  irq_mask;                 // Event enables.
  logic [3:0]  tad_count;                // Bit periods elapsed.
  adc_pkg::conv_state_t state;           // Sequencer state.
  adc_pkg::conv_state_t next_state;      // Sequencer next state.

  ////////////////////////////////////////////////////////////////////////////
  // Address decode.

  // Writes take effect at the edge that samples the strobe.
  wire wr_run  = write & (addr == adc_pkg::ADDR_RUN_CTRL);
  wire wr_ref  = write & (addr == adc_pkg::ADDR_REF_PIN);
  wire wr_clk  = write & (addr == adc_pkg::ADDR_CLK_FMT);
  wire wr_stat = write & (addr == adc_pkg::ADDR_IRQ_STATUS);
  wire wr_mask = write & (addr == adc_pkg::ADDR_IRQ_MASK);

  // The enable that applies after this write, so enable and go may be set together.
  wire new_enable = wdata[adc_pkg::ENABLE_BIT];
  wire new_go     = wdata[adc_pkg::GO_BIT];

  // A start needs the converter on and no conversion running.
  wire start_req  = wr_run & new_go & new_enable & (state == adc_pkg::ST_IDLE);
  // Asking for go with the converter off is recorded as a refused start.
  wire refused    = wr_run & new_go & ~new_enable;
  // Clearing the enable or writing go low aborts a running conversion.
  wire abort_req  = wr_run & (~new_enable | ~new_go);

  // Bit period tick from the selected clock source.
  wire tad_tick;
  // The last of the twelve bit periods ends the conversion.
  wire last_tad   = tad_tick & (tad_count == adc_pkg::TAD_PER_CONV - 4'h1);
  wire complete   = (state == adc_pkg::ST_CONVERT) & last_tad & ~abort_req;

  ////////////////////////////////////////////////////////////////////////////
  // Result formatting and read mux.

  // Left justify leaves the six spare low bits at zero.
  // Right justify puts the top two bits low in the high byte.
  wire [7:0] next_high = result_justify_select ?
                         {6'h00, core_result[9:8]} : core_result[9:2];
  wire [7:0] next_low  = result_justify_select ?
                         core_result[7:0] : {core_result[1:0], 6'h00};

  // Unimplemented top bits read as zero; unmapped addresses read zero.
  wire [7:0] run_view  = {2'h0, input_channel_select, go_done, module_enable_bit};
  wire [7:0] ref_view  = {2'h0, reference_select, pin_function_select};
  wire [7:0] clk_view  = {result_justify_select, 4'h0, conversion_clock_select};
  // Reads have no side effects, so status may be polled.
  wire [7:0] read_mux  = (addr == adc_pkg::ADDR_RUN_CTRL)   ? run_view :
                         (addr == adc_pkg::ADDR_REF_PIN)    ? ref_view :
                         (addr == adc_pkg::ADDR_CLK_FMT)    ? clk_view :
                         (addr == adc_pkg::ADDR_RES_HIGH)   ? result_high_byte :
                         (addr == adc_pkg::ADDR_RES_LOW)    ? result_low_byte :
                         (addr == adc_pkg::ADDR_IRQ_STATUS) ? {6'h00, irq_status} :
                         (addr == adc_pkg::ADDR_IRQ_MASK)   ? {6'h00, irq_mask} :
                                                              8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Outputs toward the core.

  // The multiplexer ignores the channel code while this is low.
  // Codes above the bonded-out channels route nothing to the converter.
  assign channel_valid = ({1'b0, input_channel_select} < 5'(NUM_CHANNELS));
  // The power switch follows the enable bit directly.
  assign converter_on  = module_enable_bit;
  assign conv_active   = (state == adc_pkg::ST_CONVERT);
  assign conv_bit_tick = tad_tick & conv_active;
  // Interrupt is a level while any unmasked event is pending.
  assign irq           = |(irq_status & irq_mask);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers.

  // Bit period source runs only while converting, so the first period is whole.
  // The oscillator bypasses the divider, so its first period may be short.
  conv_clock_divider u_divider (
    .clk          (clk),
    .resetn       (resetn),
    .ce           (ce),
    .run          (conv_active),
    .clock_select (conversion_clock_select),
    .rc_tick      (rc_tick),
    .tick         (tad_tick)
  );

  // Pin function decoder, trimmed to the channels present.
  // Its mask is registered, one cycle behind the pin code.
  pin_config_decode #(
    .NUM_CHANNELS (NUM_CHANNELS)
  ) u_pins (
    .clk                 (clk),
    .resetn              (resetn),
    .ce                  (ce),
    .pin_function_select (pin_function_select),
    .analog_pin_mask     (analog_pin_mask)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer.

  // One conversion at a time; a start while busy is ignored.
  // Next state: a start enters conversion, completion or abort leaves it.
  always_comb begin
    next_state = state;
    case (state)
      // Idle waits for an accepted start.
      adc_pkg::ST_IDLE: begin
        if (start_req) begin
          next_state = adc_pkg::ST_CONVERT;
        end
      end
      // Abort and last tick both leave; only the tick loads a result.
      adc_pkg::ST_CONVERT: begin
        if (abort_req || last_tad) begin
          next_state = adc_pkg::ST_IDLE;
        end
      end
      // Unused codes fall back to idle rather than lock up.
      default: begin
        next_state = adc_pkg::ST_IDLE;
      end
    endcase
  end

  // State and bit period count.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      // Reset aborts any conversion in flight.
      state     <= adc_pkg::ST_IDLE;
      tad_count <= 4'h0;
    end else if (ce) begin
      state     <= next_state;
      // A start clears the count so every conversion gets twelve periods.
      if (next_state != adc_pkg::ST_CONVERT || start_req) begin
        tad_count <= 4'h0;
      end else if (tad_tick) begin
        tad_count <= tad_count + 4'h1;
      end
    end
  end

  // The core is told to begin sampling with a one-cycle pulse.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      conv_start <= 1'b0;
    end else if (ce) begin
      // The pulse trails the start write by one cycle, as go does.
      conv_start <= start_req;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers.

  // Run control; go follows the sequencer so it clears by itself at the end.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      // Reset turns the converter off.
      module_enable_bit    <= adc_pkg::RUN_CTRL_RESET[adc_pkg::ENABLE_BIT];
      go_done              <= adc_pkg::RUN_CTRL_RESET[adc_pkg::GO_BIT];
      input_channel_select <= adc_pkg::RUN_CTRL_RESET[5:2];
    end else if (ce) begin
      // Software owns enable and channel; the sequencer owns go.
      if (wr_run) begin
        module_enable_bit    <= new_enable;
        input_channel_select <= wdata[adc_pkg::CHAN_LSB +: 4];
      end
      // Go reads one from the cycle after a start through the cycle of the last tick or abort.
      go_done <= (next_state == adc_pkg::ST_CONVERT);
    end
  end

  // Reference, pin function and clock/format fields.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      reference_select        <= adc_pkg::REF_PIN_RESET[5:4];
      pin_function_select     <= adc_pkg::REF_PIN_RESET[3:0];
      result_justify_select   <= adc_pkg::CLK_FMT_RESET[3];
      conversion_clock_select <= adc_pkg::CLK_FMT_RESET[2:0];
    end else if (ce) begin
      // Reference and pin code share one register.
      if (wr_ref) begin
        reference_select    <= wdata[adc_pkg::REF_LSB +: 2];
        pin_function_select <= wdata[adc_pkg::PIN_LSB +: 4];
      end
      // A clock code change mid-run upsets the current period.
      if (wr_clk) begin
        result_justify_select   <= wdata[adc_pkg::JUSTIFY_BIT];
        conversion_clock_select <= wdata[adc_pkg::CLKSEL_LSB +: 3];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Result registers.

  // Loaded only on completion; an aborted conversion leaves the old result.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      // Zeros rather than leftover data after reset.
      result_high_byte <= adc_pkg::RESULT_RESET;
      result_low_byte  <= adc_pkg::RESULT_RESET;
    end else if (ce && complete) begin
      result_high_byte <= next_high;
      result_low_byte  <= next_low;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status, mask and read data.

  // Write one clears a status bit, but a new event in the same cycle wins.
  // Bit 0 marks a finished conversion, bit 1 a start refused while off.
  wire [1:0] irq_set = {refused, complete};
  wire [1:0] irq_clr = wr_stat ? wdata[1:0] : 2'h0;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      // Reset drops pending events and masks them all.
      irq_status <= adc_pkg::IRQ_RESET;
      irq_mask   <= adc_pkg::IRQ_RESET;
    end else if (ce) begin
      irq_status <= (irq_status & ~irq_clr) | irq_set;
      // The mask gates only the output; masked events are still kept.
      if (wr_mask) begin
        irq_mask <= wdata[1:0];
      end
    end
  end

  // Read data stand only in the cycle after the read strobe.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rdata <= 8'h00;
    end else if (ce) begin
      // Zero between reads keeps a shared read bus quiet.
      rdata <= read ? read_mux : 8'h00;
    end
  end

endmodule

// ### src/conv_clock_divider.sv
// Bit period tick generator for the conversion sequencer.
// Assumes rc_tick is a one-cycle pulse synchronous to clk.
`timescale 1ns/1ns
module conv_clock_divider (
  // Clock, reset, enable.
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       ce,
  // Control.
  input  wire logic       run,
  input  wire logic [2:0] clock_select,
  input  wire logic       rc_tick,
  // Tick out.
  output logic            tick
);

  logic [6:0] count;    // Cycles counted in the current period.
  logic [6:0] divisor;  // Period length for the selected code.
  logic       use_rc;   // The internal oscillator paces the bits.
  logic       wrap;     // Last cycle of a divided period.

  // Map the select code to a divisor; x11 picks the RC oscillator.
  assign divisor = (clock_select == 3'h0) ? adc_pkg::DIV_2  :
                   (clock_select == 3'h1) ? adc_pkg::DIV_8  :
                   (clock_select == 3'h2) ? adc_pkg::DIV_32 :
                   (clock_select == 3'h4) ? adc_pkg::DIV_4  :
                   (clock_select == 3'h5) ? adc_pkg::DIV_16 :
                                            adc_pkg::DIV_64;
  assign use_rc = (clock_select[1:0] == 2'h3);
  assign wrap   = (count == divisor - 7'h01);
  assign tick   = run & (use_rc ? rc_tick : wrap);

  // The counter restarts when idle so every divided-clock conversion begins on a full period.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      count <= 7'h00;
    end else if (ce) begin
      if (!run || wrap || use_rc) begin
        count <= 7'h00;
      end else begin
        count <= count + 7'h01;
      end
    end
  end

endmodule

// ### src/pin_config_decode.sv
// Decodes the pin function code into a mask of analog channels.
// Assumes the pin code is a stable register value.
`timescale 1ns/1ns
module pin_config_decode #(
  parameter int NUM_CHANNELS = 16
) (
  // Clock, reset, enable.
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        ce,
  // Pin function code.
  input  wire logic [3:0]  pin_function_select,
  // One bit per channel, high where the pin is analog.
  output logic      [15:0] analog_pin_mask
);

  logic [4:0]  digital_count;  // Channels turned digital from the top.
  logic [16:0] full_mask;      // Low channels left analog.
  logic [15:0] present_mask;   // Channels bonded out on this package.

  // Code 0 keeps all analog, 15 makes all digital, code k makes k+1 digital.
  assign digital_count = (pin_function_select == 4'h0) ? 5'h00 :
                         (pin_function_select == 4'hF) ? 5'h10 :
                         {1'b0, pin_function_select} + 5'h01;
  assign full_mask     = (17'h00001 << (5'h10 - digital_count)) - 17'h00001;
  // Absent channels on the small package can never be analog.
  assign present_mask  = 16'((17'h00001 << NUM_CHANNELS) - 17'h00001);

  // Registered so the pad controls do not glitch during decode.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      analog_pin_mask <= 16'h0000;
    end else if (ce) begin
      analog_pin_mask <= full_mask[15:0] & present_mask;
    end
  end

endmodule
